// ==== hw/lbod_core.sv ====
/*
  Logic and bit-operation execution datapath of an 8-bit single-cycle core.
  Assumes the decoder drives one opcode per clock with its memory operand
  already read, and that the memory takes MEM_WE writes one cycle later.
*/
// What this block does
// - and accumulator with immediate or memory byte
// - or accumulator with operand, zero only
// - xor accumulator with operand, zero only
// - xor accumulator into io register, no flags
// - invert accumulator or memory, zero only
// - negate accumulator or memory, zero only
// - compare accumulator minus memory sets flags
// - compare memory minus accumulator sets flags
// - borrow on compare sets carry
// - clear one io bit, flags kept
// - set one io bit, flags kept
// - bit exchange swaps io bit with carry
// - output bit takes old carry on exchange
// - input pin loads carry on exchange
// - direction bit one makes pin output
// - clear one memory bit, flags kept
// - set one memory bit, flags kept
// - memory bit ops only below 0x40
// - zero flag follows result equal zero
`default_nettype none

module lbod_core (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [4:0] OP_CODE,
  input wire logic [7:0] OP_IMM,
  input wire logic [2:0] OP_BIT,
  input wire logic IO_SEL,
  input wire logic [7:0] MEM_ADDR,
  input wire logic [7:0] MEM_RDATA,
  input wire logic ACC_LOAD,
  input wire logic [7:0] ACC_LOAD_DATA,
  input wire logic [7:0] PA_IN,
  output logic [7:0] ACC,
  output logic FLAG_Z,
  output logic FLAG_C,
  output logic FLAG_AC,
  output logic FLAG_OV,
  output logic [7:0] PA_OUT,
  output logic [7:0] PA_DIR,
  output logic [7:0] PA_OE_N,
  output logic MEM_WE,
  output logic [7:0] MEM_WADDR,
  output logic [7:0] MEM_WDATA,
  output logic BIT_ADDR_ERR
);
  lbod_pkg::lbod_state_t s_reg;
  lbod_pkg::lbod_state_t s_next;
  lbod_pkg::lbod_op_t op;
  logic [7:0] mask;
  logic [7:0] io_val;

  // flags of x minus y as {z, c, ac, ov}; carry and half carry mean borrow
  function automatic logic [3:0] sub_flags(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] d;
    logic hb;
    logic z;
    logic ov;
    d = {1'b0, x} - {1'b0, y};
    hb = (x[lbod_pkg::NIB-1:0] < y[lbod_pkg::NIB-1:0]);
    z = (d[7:0] == lbod_pkg::BYTE_ZERO);
    ov = (x[7] != y[7]) && (d[7] != x[7]);
    return {z, d[8], hb, ov};
  endfunction

  assign op = lbod_pkg::lbod_op_t'(OP_CODE);
  assign mask = lbod_pkg::BYTE_ONE << OP_BIT;
  assign io_val = (IO_SEL == lbod_pkg::IO_SEL_DIR) ? s_reg.dir : s_reg.pa;

  // next state: every instruction completes in this single evaluation
  always_comb
  begin
    logic [7:0] r;
    r = lbod_pkg::BYTE_ZERO;
    s_next = s_reg;
    s_next.mem_we = 1'b0; // write strobe is a one-cycle pulse
    s_next.addr_err = 1'b0;
    unique case (op)
      lbod_pkg::OP_NOP:
      begin
        // other units may load the accumulator only in an idle slot
        if (ACC_LOAD)
        begin
          s_next.acc = ACC_LOAD_DATA;
        end
      end
      lbod_pkg::OP_AND_AI, lbod_pkg::OP_AND_AM, lbod_pkg::OP_AND_MA:
      begin
        r = s_reg.acc & ((op == lbod_pkg::OP_AND_AI) ? OP_IMM : MEM_RDATA);
        s_next.z = (r == lbod_pkg::BYTE_ZERO);
        if (op == lbod_pkg::OP_AND_MA)
        begin
          s_next.mem_we = 1'b1;
          s_next.mem_addr = MEM_ADDR;
          s_next.mem_wdata = r;
        end
        else
        begin
          s_next.acc = r;
        end
      end
      lbod_pkg::OP_OR_AI, lbod_pkg::OP_OR_AM, lbod_pkg::OP_OR_MA:
      begin
        r = s_reg.acc | ((op == lbod_pkg::OP_OR_AI) ? OP_IMM : MEM_RDATA);
        s_next.z = (r == lbod_pkg::BYTE_ZERO);
        if (op == lbod_pkg::OP_OR_MA)
        begin
          s_next.mem_we = 1'b1;
          s_next.mem_addr = MEM_ADDR;
          s_next.mem_wdata = r;
        end
        else
        begin
          s_next.acc = r;
        end
      end
      lbod_pkg::OP_XOR_AI, lbod_pkg::OP_XOR_AM, lbod_pkg::OP_XOR_MA:
      begin
        r = s_reg.acc ^ ((op == lbod_pkg::OP_XOR_AI) ? OP_IMM : MEM_RDATA);
        s_next.z = (r == lbod_pkg::BYTE_ZERO);
        if (op == lbod_pkg::OP_XOR_MA)
        begin
          s_next.mem_we = 1'b1;
          s_next.mem_addr = MEM_ADDR;
          s_next.mem_wdata = r;
        end
        else
        begin
          s_next.acc = r;
        end
      end
      lbod_pkg::OP_XOR_IO, lbod_pkg::OP_CLR_IO, lbod_pkg::OP_SET_IO:
      begin
        if (op == lbod_pkg::OP_XOR_IO)
        begin
          r = s_reg.acc ^ io_val;
        end
        else if (op == lbod_pkg::OP_CLR_IO)
        begin
          r = io_val & ~mask;
        end
        else
        begin
          r = io_val | mask;
        end
        // a write to the direction register also retimes the enables
        if (IO_SEL == lbod_pkg::IO_SEL_DIR)
        begin
          s_next.dir = r;
          s_next.oe_n = ~r;
        end
        else
        begin
          s_next.pa = r;
        end
      end
      lbod_pkg::OP_NOT_A, lbod_pkg::OP_NEG_A:
      begin
        r = (op == lbod_pkg::OP_NOT_A) ? ~s_reg.acc : -s_reg.acc;
        s_next.acc = r;
        s_next.z = (r == lbod_pkg::BYTE_ZERO);
      end
      lbod_pkg::OP_NOT_M, lbod_pkg::OP_NEG_M:
      begin
        r = (op == lbod_pkg::OP_NOT_M) ? ~MEM_RDATA : -MEM_RDATA;
        s_next.z = (r == lbod_pkg::BYTE_ZERO);
        s_next.mem_we = 1'b1;
        s_next.mem_addr = MEM_ADDR;
        s_next.mem_wdata = r;
      end
      lbod_pkg::OP_CMP_AM:
      begin
        // only the flags move; no data write is issued
        {s_next.z, s_next.c, s_next.ac, s_next.ov} = sub_flags(s_reg.acc, MEM_RDATA);
      end
      lbod_pkg::OP_CMP_MA:
      begin
        {s_next.z, s_next.c, s_next.ac, s_next.ov} = sub_flags(MEM_RDATA, s_reg.acc);
      end
      lbod_pkg::OP_SWAPC:
      begin
        // the latch always takes old carry; carry source depends on direction
        s_next.pa = (s_reg.pa & ~mask) | (s_reg.c ? mask : lbod_pkg::BYTE_ZERO);
        if ((s_reg.dir & mask) != lbod_pkg::BYTE_ZERO)
        begin
          s_next.c = ((s_reg.pa & mask) != lbod_pkg::BYTE_ZERO);
        end
        else
        begin
          s_next.c = ((PA_IN & mask) != lbod_pkg::BYTE_ZERO);
        end
      end
      lbod_pkg::OP_CLR_M, lbod_pkg::OP_SET_M:
      begin
        // out-of-range bit ops are dropped so no stray byte is corrupted
        if (MEM_ADDR > lbod_pkg::BIT_MEM_LAST)
        begin
          s_next.addr_err = 1'b1;
        end
        else
        begin
          s_next.mem_we = 1'b1;
          s_next.mem_addr = MEM_ADDR;
          if (op == lbod_pkg::OP_CLR_M)
          begin
            s_next.mem_wdata = MEM_RDATA & ~mask;
          end
          else
          begin
            s_next.mem_wdata = MEM_RDATA | mask;
          end
        end
      end
      default:
      begin
        s_next = s_reg;
        s_next.mem_we = 1'b0;
        s_next.addr_err = 1'b0;
      end
    endcase
  end

  // single register stage; results visible next instruction
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      s_reg <= '{acc: lbod_pkg::BYTE_ZERO, z: 1'b0, c: 1'b0, ac: 1'b0, ov: 1'b0,
                 pa: lbod_pkg::BYTE_ZERO, dir: lbod_pkg::BYTE_ZERO, oe_n: ~lbod_pkg::BYTE_ZERO,
                 mem_we: 1'b0, mem_addr: lbod_pkg::BYTE_ZERO, mem_wdata: lbod_pkg::BYTE_ZERO,
                 addr_err: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flops
  assign ACC = s_reg.acc;
  assign FLAG_Z = s_reg.z;
  assign FLAG_C = s_reg.c;
  assign FLAG_AC = s_reg.ac;
  assign FLAG_OV = s_reg.ov;
  assign PA_OUT = s_reg.pa;
  assign PA_DIR = s_reg.dir;
  assign PA_OE_N = s_reg.oe_n;
  assign MEM_WE = s_reg.mem_we;
  assign MEM_WADDR = s_reg.mem_addr;
  assign MEM_WDATA = s_reg.mem_wdata;
  assign BIT_ADDR_ERR = s_reg.addr_err;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  // checks tying each result to the operands of the cycle before
  property p_and_imm;
    op == lbod_pkg::OP_AND_AI |=> ACC == ($past(ACC) & $past(OP_IMM)) && FLAG_Z == (ACC == lbod_pkg::BYTE_ZERO)
      && $stable(FLAG_C) && $stable(FLAG_AC) && $stable(FLAG_OV);
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("and immediate result wrong");

  property p_or_mem;
    op == lbod_pkg::OP_OR_MA |=> MEM_WE && MEM_WDATA == ($past(ACC) | $past(MEM_RDATA)) && $stable(ACC)
      && $stable(FLAG_C);
  endproperty
  a_or_mem: assert property (p_or_mem) else $error("or to memory wrong");

  property p_xor_io;
    op == lbod_pkg::OP_XOR_IO && IO_SEL == lbod_pkg::IO_SEL_DATA |=> PA_OUT == ($past(ACC) ^ $past(PA_OUT))
      && $stable({FLAG_Z, FLAG_C, FLAG_AC, FLAG_OV});
  endproperty
  a_xor_io: assert property (p_xor_io) else $error("xor into port wrong");

  property p_neg_acc;
    op == lbod_pkg::OP_NEG_A |=> ACC == lbod_pkg::DW'(lbod_pkg::BYTE_ZERO - $past(ACC)) && $stable(FLAG_C);
  endproperty
  a_neg_acc: assert property (p_neg_acc) else $error("negate wrong");

  property p_cmp_borrow;
    op == lbod_pkg::OP_CMP_AM && ACC < MEM_RDATA |=> FLAG_C && !FLAG_Z && !MEM_WE && $stable(ACC);
  endproperty
  a_cmp_borrow: assert property (p_cmp_borrow) else $error("compare borrow wrong");

  property p_cmp_ma;
    op == lbod_pkg::OP_CMP_MA && MEM_RDATA == ACC |=> FLAG_Z && !FLAG_C && !FLAG_AC && !FLAG_OV;
  endproperty
  a_cmp_ma: assert property (p_cmp_ma) else $error("compare equal flags wrong");

  property p_set_io;
    op == lbod_pkg::OP_SET_IO && IO_SEL == lbod_pkg::IO_SEL_DIR |=> PA_DIR == ($past(PA_DIR) | $past(mask))
      && PA_OE_N == ~PA_DIR;
  endproperty
  a_set_io: assert property (p_set_io) else $error("direction set wrong");

  property p_swap_out;
    op == lbod_pkg::OP_SWAPC && (s_reg.dir & mask) != lbod_pkg::BYTE_ZERO && FLAG_C |=>
      (PA_OUT & $past(mask)) != lbod_pkg::BYTE_ZERO && FLAG_C == (($past(PA_OUT) & $past(mask)) != lbod_pkg::BYTE_ZERO);
  endproperty
  a_swap_out: assert property (p_swap_out) else $error("exchange output wrong");

  property p_swap_in;
    op == lbod_pkg::OP_SWAPC && (s_reg.dir & mask) == lbod_pkg::BYTE_ZERO |=>
      FLAG_C == (($past(PA_IN) & $past(mask)) != lbod_pkg::BYTE_ZERO) && $stable(FLAG_Z);
  endproperty
  a_swap_in: assert property (p_swap_in) else $error("exchange input wrong");

  property p_bit_range;
    (op == lbod_pkg::OP_SET_M || op == lbod_pkg::OP_CLR_M) && MEM_ADDR > lbod_pkg::BIT_MEM_LAST |=>
      !MEM_WE && BIT_ADDR_ERR;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit op out of range written");

  property p_clr_mem;
    op == lbod_pkg::OP_CLR_M && MEM_ADDR <= lbod_pkg::BIT_MEM_LAST |=> MEM_WE
      && MEM_WDATA == ($past(MEM_RDATA) & ~$past(mask)) && $stable({FLAG_Z, FLAG_C});
  endproperty
  a_clr_mem: assert property (p_clr_mem) else $error("memory bit clear wrong");

  // set path must hit the same address and leave every flag alone
  property p_set_mem;
    op == lbod_pkg::OP_SET_M && MEM_ADDR <= lbod_pkg::BIT_MEM_LAST |=> MEM_WE && MEM_WADDR == $past(MEM_ADDR)
      && MEM_WDATA == ($past(MEM_RDATA) | $past(mask)) && $stable({FLAG_Z, FLAG_C, FLAG_AC, FLAG_OV});
  endproperty
  a_set_mem: assert property (p_set_mem) else $error("memory bit set wrong");

  // accumulator-destination xor issues no memory write
  property p_xor_acc;
    op == lbod_pkg::OP_XOR_AM |=> ACC == ($past(ACC) ^ $past(MEM_RDATA)) && !MEM_WE
      && $stable({FLAG_C, FLAG_AC, FLAG_OV});
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor from memory wrong");

  property p_not_acc;
    op == lbod_pkg::OP_NOT_A |=> ACC == ~$past(ACC) && FLAG_Z == (ACC == lbod_pkg::BYTE_ZERO) && $stable(FLAG_C);
  endproperty
  a_not_acc: assert property (p_not_acc) else $error("invert wrong");
endmodule

`default_nettype wire

// ==== hw/lbod_pkg.sv ====
/*
  Shared constants and types for the logic and bit-operation datapath.
  Assumes an 8-bit core whose decoder presents one instruction per clock.
*/
`default_nettype none

package lbod_pkg;
  localparam int DW = 8;
  localparam int NIB = 4;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BIT_MEM_LAST = 8'h3f;
  localparam logic IO_SEL_DATA = 1'b0;
  localparam logic IO_SEL_DIR = 1'b1;

  // instruction codes presented by the decoder
  typedef enum logic [4:0] {
    OP_NOP    = 5'b00000,
    OP_AND_AI = 5'b00001,
    OP_AND_AM = 5'b00010,
    OP_AND_MA = 5'b00011,
    OP_OR_AI  = 5'b00100,
    OP_OR_AM  = 5'b00101,
    OP_OR_MA  = 5'b00110,
    OP_XOR_AI = 5'b00111,
    OP_XOR_AM = 5'b01000,
    OP_XOR_MA = 5'b01001,
    OP_XOR_IO = 5'b01010,
    OP_NOT_A  = 5'b01011,
    OP_NOT_M  = 5'b01100,
    OP_NEG_A  = 5'b01101,
    OP_NEG_M  = 5'b01110,
    OP_CMP_AM = 5'b01111,
    OP_CMP_MA = 5'b10000,
    OP_CLR_IO = 5'b10001,
    OP_SET_IO = 5'b10010,
    OP_SWAPC  = 5'b10011,
    OP_CLR_M  = 5'b10100,
    OP_SET_M  = 5'b10101
  } lbod_op_t;

  // whole state of the datapath
  typedef struct packed {
    logic [7:0] acc;
    logic z;
    logic c;
    logic ac;
    logic ov;
    logic [7:0] pa;
    logic [7:0] dir;
    logic [7:0] oe_n;
    logic mem_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic addr_err;
  } lbod_state_t;
endpackage

`default_nettype wire

// ==== sim/lbod_far_side.sv ====
/*
  Far-side model: data memory behind the datapath and the port A pins.
  Assumes writes land on the rising edge and reads are combinational.
*/
`default_nettype none

module lbod_far_side (
  input wire logic sys_clk,
  input wire logic [7:0] mem_addr,
  output logic [7:0] mem_rdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_waddr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe_n,
  input wire logic [7:0] ext_pins,
  output logic [7:0] pa_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];

  // fill is zero only at address 159, so a lost write seldom hides behind a zero
  initial
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i * 37 + 5);

  // write strobe taken on the edge, read by the next op
  always @(posedge sys_clk)
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;

  // forward the pending write so back-to-back ops see it
  assign mem_rdata = (mem_we && mem_waddr == mem_addr) ? mem_wdata : mem[mem_addr];
  // undriven pins follow whatever the outside world drives
  assign pa_in = (pa_out & ~pa_oe_n) | (ext_pins & pa_oe_n);
endmodule

`default_nettype wire

// ==== sim/tb_logic_and_bit_op_datapath.sv ====
/*
  Self-checking bench for the logic and bit-operation datapath.
  Assumes lbod_pkg, lbod_core and the far-side model are compiled first.
*/
`default_nettype none

module tb_logic_and_bit_op_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] op_code = 5'h00;
  logic [7:0] op_imm = 8'h00;
  logic [2:0] op_bit = 3'h0;
  logic io_sel = 1'b0;
  logic [7:0] mem_addr = 8'h00;
  logic acc_load = 1'b0;
  logic [7:0] acc_load_data = 8'h00;
  logic [7:0] ext_pins = 8'h00;
  logic [7:0] mem_rdata, pa_in, acc, pa_out, pa_dir, pa_oe_n, mem_waddr, mem_wdata;
  logic flag_z, flag_c, flag_ac, flag_ov, mem_we, bit_addr_err;
  logic [7:0] m_acc = 8'h00, m_pa = 8'h00, m_dir = 8'h00;
  logic m_z = 1'b0, m_c = 1'b0, m_ac = 1'b0, m_ov = 1'b0;
  logic [53:0] exp_q[$];
  logic [53:0] got;
  logic [31:0] r;
  int seed = 7;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  lbod_core DUT (.SYS_CLK(sys_clk), .RST(rst), .OP_CODE(op_code), .OP_IMM(op_imm), .OP_BIT(op_bit),
    .IO_SEL(io_sel), .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata), .ACC_LOAD(acc_load),
    .ACC_LOAD_DATA(acc_load_data), .PA_IN(pa_in), .ACC(acc), .FLAG_Z(flag_z), .FLAG_C(flag_c),
    .FLAG_AC(flag_ac), .FLAG_OV(flag_ov), .PA_OUT(pa_out), .PA_DIR(pa_dir), .PA_OE_N(pa_oe_n),
    .MEM_WE(mem_we), .MEM_WADDR(mem_waddr), .MEM_WDATA(mem_wdata), .BIT_ADDR_ERR(bit_addr_err));

  lbod_far_side far (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
    .ext_pins(ext_pins), .pa_in(pa_in));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // drive one op at the falling edge; v is immediate, address and load data
  task automatic run_op(input logic [4:0] c, input logic [7:0] v, input logic [2:0] b, input logic s,
    input logic ld);
    logic [7:0] md, x, y, io, res, wd;
    logic [8:0] d;
    logic we, err, t;
    @(negedge sys_clk);
    op_code = c;
    op_imm = v;
    op_bit = b;
    io_sel = s;
    mem_addr = v;
    acc_load = ld;
    acc_load_data = v;
    ext_pins = 8'($random(seed));
    #1;
    md = mem_rdata;
    x = (c inside {5'h01, 5'h04, 5'h07}) ? v : md;
    we = 1'b0;
    err = 1'b0;
    wd = 8'h00;
    case (c)
      5'h01, 5'h02, 5'h03: res = m_acc & x;
      5'h04, 5'h05, 5'h06: res = m_acc | x;
      5'h07, 5'h08, 5'h09: res = m_acc ^ x;
      5'h0b, 5'h0c: res = ~(c[0] ? m_acc : md);
      5'h0d, 5'h0e: res = -(c[0] ? m_acc : md);
      default: res = 8'h00;
    endcase
    if (c inside {[5'h01:5'h09], [5'h0b:5'h0e]})
    begin
      m_z = (res == 8'h00);
      we = c inside {5'h03, 5'h06, 5'h09, 5'h0c, 5'h0e};
      wd = res;
      if (!we)
        m_acc = res;
    end
    // compares touch flags only, carry is the borrow
    if (c == 5'h0f || c == 5'h10)
    begin
      x = c[0] ? m_acc : md;
      y = c[0] ? md : m_acc;
      d = {1'b0, x} - {1'b0, y};
      m_z = (d[7:0] == 8'h00);
      m_c = d[8];
      m_ac = (x[3:0] < y[3:0]);
      m_ov = (x[7] ^ y[7]) & (x[7] ^ d[7]);
    end
    io = s ? m_dir : m_pa;
    if (c == 5'h0a)
      io = io ^ m_acc;
    if (c == 5'h11)
      io[b] = 1'b0;
    if (c == 5'h12)
      io[b] = 1'b1;
    if (c inside {5'h0a, 5'h11, 5'h12} && s)
      m_dir = io;
    if (c inside {5'h0a, 5'h11, 5'h12} && !s)
      m_pa = io;
    if (c == 5'h13)
    begin
      t = m_c;
      m_c = m_dir[b] ? m_pa[b] : pa_in[b];
      m_pa[b] = t;
    end
    if (c == 5'h14 || c == 5'h15)
    begin
      err = (v > 8'h3f);
      we = !err;
      wd = md;
      wd[b] = c[0];
    end
    if (c == 5'h00 && ld)
      m_acc = v;
    exp_q.push_back({m_acc, m_z, m_c, m_ac, m_ov, m_pa, m_dir, ~m_dir, we, we ? v : 8'h00, we ? wd : 8'h00, err});
  endtask

  // results land one edge after the op; write fields only matter with the strobe
  always @(posedge sys_clk)
  begin
    #1;
    if (exp_q.size() > 0)
    begin
      got = {acc, flag_z, flag_c, flag_ac, flag_ov, pa_out, pa_dir, pa_oe_n, mem_we,
        mem_waddr & {8{mem_we}}, mem_wdata & {8{mem_we}}, bit_addr_err};
      checks_done++;
      if (got !== exp_q[0])
      begin
        num_errors++;
        $display("BAD outputs expected %h seen %h", exp_q[0], got);
      end
      void'(exp_q.pop_front());
    end
  end

  // hang guard, far above the roughly 430 cycles needed
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    run_op(5'h00, 8'h00, 3'h0, 1'b0, 1'b0);
    run_op(5'h00, 8'h38, 3'h0, 1'b0, 1'b1);
    run_op(5'h0b, 8'h00, 3'h0, 1'b0, 1'b0);
    run_op(5'h00, 8'h38, 3'h0, 1'b0, 1'b1);
    run_op(5'h0d, 8'h00, 3'h0, 1'b0, 1'b0);
    $display("test invert done");
    run_op(5'h00, 8'h00, 3'h0, 1'b0, 1'b1);
    run_op(5'h03, 8'h20, 3'h0, 1'b0, 1'b0);
    run_op(5'h00, 8'h42, 3'h0, 1'b0, 1'b1);
    run_op(5'h06, 8'h20, 3'h0, 1'b0, 1'b0);
    run_op(5'h00, 8'h38, 3'h0, 1'b0, 1'b1);
    run_op(5'h0f, 8'h20, 3'h0, 1'b0, 1'b0);
    run_op(5'h10, 8'h20, 3'h0, 1'b0, 1'b0);
    run_op(5'h00, 8'h42, 3'h0, 1'b0, 1'b1);
    run_op(5'h0f, 8'h20, 3'h0, 1'b0, 1'b0);
    $display("test compare done");
    run_op(5'h12, 8'h00, 3'h3, 1'b1, 1'b0);
    run_op(5'h13, 8'h00, 3'h3, 1'b0, 1'b0);
    run_op(5'h13, 8'h00, 3'h3, 1'b0, 1'b0);
    run_op(5'h11, 8'h00, 3'h3, 1'b1, 1'b0);
    run_op(5'h13, 8'h00, 3'h3, 1'b0, 1'b0);
    run_op(5'h00, 8'ha5, 3'h0, 1'b0, 1'b1);
    run_op(5'h0a, 8'h00, 3'h0, 1'b0, 1'b0);
    run_op(5'h12, 8'h00, 3'h7, 1'b0, 1'b0);
    run_op(5'h11, 8'h00, 3'h0, 1'b0, 1'b0);
    $display("test port done");
    run_op(5'h15, 8'h3f, 3'h7, 1'b0, 1'b0);
    run_op(5'h15, 8'h40, 3'h7, 1'b0, 1'b0);
    run_op(5'h14, 8'h00, 3'h0, 1'b0, 1'b0);
    $display("test bit range done");
    repeat (400)
    begin
      r = $random(seed);
      run_op(r[4:0], r[15:8], r[7:5], r[16], r[17]);
    end
    $display("test random done");
    run_op(5'h00, 8'h00, 3'h0, 1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
    #2;
    wrap_up();
  end
endmodule

`default_nettype wire
